//--- slsp_cfg.svh
// constants of the serial link sample packer: mode codes, frame shapes
// assumes inclusion by bare name before the package and the packer module
`ifndef SLSP_CFG_SVH
`define SLSP_CFG_SVH

// ----------------------------------------------------------------
// link mode setting
// ----------------------------------------------------------------
`define SLSP_MODE_W        5
`define SLSP_MODE_RESET    5'h0_001
`define SLSP_MODE_1        5'h0_001
`define SLSP_MODE_2        5'h0_002
`define SLSP_MODE_3        5'h0_003
`define SLSP_MODE_4        5'h0_004
`define SLSP_MODE_5        5'h0_005
`define SLSP_MODE_6        5'h0_006
`define SLSP_MODE_7        5'h0_007
`define SLSP_MODE_8        5'h0_008
`define SLSP_MODE_9        5'h0_009
`define SLSP_MODE_10       5'h0_00a

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define SLSP_CHANNELS      4
`define SLSP_SAMPLE_W      12
`define SLSP_SAMPLES       8
`define SLSP_LANES         8
`define SLSP_OCTETS        5
`define SLSP_CNT_W         4

`endif

//--- slsp_pkg.sv
// types shared by the serial link sample packer
// assumes slsp_cfg.svh sits in the same folder
`include "slsp_cfg.svh"

package slsp_pkg;
    typedef logic [`SLSP_MODE_W-1:0]     slsp_mode_t;
    typedef logic [`SLSP_SAMPLE_W-1:0]   slsp_sample_t;
    typedef logic [`SLSP_OCTETS*8-1:0]   slsp_lane_t;
    typedef logic [`SLSP_CNT_W-1:0]      slsp_cnt_t;
endpackage

//--- slsp_packer.sv
// transport packer: four channel sample frames into per-lane octets
// assumes one clock, synchronous inputs, samples right-justified in 12 bits
//
// What this block does
// - mode 1: 12-bit pairs over six lanes
// - mode 2: one 8-bit sample per lane
// - mode 3: four 10-bit samples per lane
// - mode 4: 12-bit samples over three lanes
// - mode 5: two 8-bit samples per lane
// - mode 6 packs like mode 1
// - mode 7 packs like mode 2
// - mode 8: two 12-bit samples per lane
// - mode 9: eight lanes, one sample each
// - mode 10: even and odd samples split lanes
// - every sample goes msb first
// - link mode setting selects frame layout
// - channels A to D, index within frame
`timescale 1ns/1ps
`include "slsp_cfg.svh"

module slsp_packer
#(
    parameter int SAMPLE_W = `SLSP_SAMPLE_W,
    parameter int LANES    = `SLSP_LANES,
    parameter int OCTETS   = `SLSP_OCTETS
)
(
    input  wire logic                                  ref_clk,
    input  wire logic                                  reset,
    input  wire logic                                  link_enable,
    input  wire slsp_pkg::slsp_mode_t                  link_mode_select,
    input  wire logic [`SLSP_SAMPLES-1:0][SAMPLE_W-1:0] samp_a,
    input  wire logic [`SLSP_SAMPLES-1:0][SAMPLE_W-1:0] samp_b,
    input  wire logic [`SLSP_SAMPLES-1:0][SAMPLE_W-1:0] samp_c,
    input  wire logic [`SLSP_SAMPLES-1:0][SAMPLE_W-1:0] samp_d,
    input  wire logic                                  in_valid,
    output logic                                       in_ready,
    output logic [LANES-1:0][OCTETS*8-1:0]             lane_octets,
    output logic                                       out_valid,
    input  wire logic                                  out_ready,
    output slsp_pkg::slsp_cnt_t                        frame_lanes,
    output slsp_pkg::slsp_cnt_t                        frame_octets,
    output logic                                       frame_64b66b,
    output logic                                       mode_bad
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (SAMPLE_W != `SLSP_SAMPLE_W || LANES != `SLSP_LANES ||
        OCTETS != `SLSP_OCTETS)
    begin : g_bad_shape
        $error("packer layouts need 12-bit samples, 8 lanes, 5 octets");
    end

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // lanes in use for a mode, zero when unsupported
    function automatic slsp_pkg::slsp_cnt_t lanes_of
    (
        input slsp_pkg::slsp_mode_t m
    );
        unique case (m)
            `SLSP_MODE_1, `SLSP_MODE_6:  lanes_of = 4'h6;
            `SLSP_MODE_2, `SLSP_MODE_7,
            `SLSP_MODE_3, `SLSP_MODE_8:  lanes_of = 4'h4;
            `SLSP_MODE_4:                lanes_of = 4'h3;
            `SLSP_MODE_5:                lanes_of = 4'h2;
            `SLSP_MODE_9, `SLSP_MODE_10: lanes_of = 4'h8;
            default:                     lanes_of = 4'h0;
        endcase
    endfunction

    // octets per lane per frame
    function automatic slsp_pkg::slsp_cnt_t octets_of
    (
        input slsp_pkg::slsp_mode_t m
    );
        unique case (m)
            `SLSP_MODE_1, `SLSP_MODE_6,
            `SLSP_MODE_4, `SLSP_MODE_5:  octets_of = 4'h2;
            `SLSP_MODE_2, `SLSP_MODE_7,
            `SLSP_MODE_9:                octets_of = 4'h1;
            `SLSP_MODE_3, `SLSP_MODE_10: octets_of = 4'h5;
            `SLSP_MODE_8:                octets_of = 4'h3;
            default:                     octets_of = 4'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // mode latch
    // ----------------------------------------------------------------
    slsp_pkg::slsp_mode_t active_mode;
    logic                 mode_ok;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            active_mode  <= `SLSP_MODE_RESET;
            frame_lanes  <= lanes_of(`SLSP_MODE_RESET);
            frame_octets <= octets_of(`SLSP_MODE_RESET);
            frame_64b66b <= 1'b0;
            mode_bad     <= 1'b0;
        end
        else if (!link_enable)
        begin
            active_mode  <= link_mode_select;
            frame_lanes  <= lanes_of(link_mode_select);
            frame_octets <= octets_of(link_mode_select);
            frame_64b66b <= (link_mode_select >= `SLSP_MODE_4) &&
                            (link_mode_select <= `SLSP_MODE_8);
            mode_bad     <= (lanes_of(link_mode_select) == 4'h0);
        end
    end

    assign mode_ok = (lanes_of(active_mode) != 4'h0);

    // ----------------------------------------------------------------
    // packing network
    // ----------------------------------------------------------------
    logic [3:0][`SLSP_SAMPLES-1:0][SAMPLE_W-1:0] smp;
    logic [LANES-1:0][OCTETS*8-1:0]              packed_lanes;

    // channel order A, B, C, D
    assign smp = {samp_d, samp_c, samp_b, samp_a};

    // layout chosen by the latched mode
    // msb first from the lane's top bit
    // sample index order is time order
    always_comb
    begin
        logic [47:0] w48;
        w48          = 48'h0000_0000_0000;
        packed_lanes = '0;
        unique case (active_mode)
            // pairs of channels over three lanes
            `SLSP_MODE_1, `SLSP_MODE_6:
            begin
                for (int p = 0; p < 2; p++)
                begin
                    w48 = {smp[2*p][0], smp[2*p][1],
                           smp[2*p+1][0], smp[2*p+1][1]};
                    packed_lanes[3*p][39:24]   = w48[47:32];
                    packed_lanes[3*p+1][39:24] = w48[31:16];
                    packed_lanes[3*p+2][39:24] = w48[15:0];
                end
            end
            `SLSP_MODE_2, `SLSP_MODE_7:
                for (int k = 0; k < 4; k++)
                    packed_lanes[k][39:32] = smp[k][0][7:0];
            // four 10-bit samples back to back
            `SLSP_MODE_3:
                for (int k = 0; k < 4; k++)
                    packed_lanes[k] = {smp[k][0][9:0], smp[k][1][9:0],
                                       smp[k][2][9:0], smp[k][3][9:0]};
            // one sample per channel over three lanes
            `SLSP_MODE_4:
            begin
                w48 = {smp[0][0], smp[1][0], smp[2][0], smp[3][0]};
                packed_lanes[0][39:24] = w48[47:32];
                packed_lanes[1][39:24] = w48[31:16];
                packed_lanes[2][39:24] = w48[15:0];
            end
            // A then B, C then D
            `SLSP_MODE_5:
            begin
                packed_lanes[0][39:24] = {smp[0][0][7:0], smp[1][0][7:0]};
                packed_lanes[1][39:24] = {smp[2][0][7:0], smp[3][0][7:0]};
            end
            `SLSP_MODE_8:
                for (int k = 0; k < 4; k++)
                    packed_lanes[k][39:16] = {smp[k][0], smp[k][1]};
            // lane 2c+i carries sample i of channel c
            `SLSP_MODE_9:
                for (int c = 0; c < 4; c++)
                    for (int i = 0; i < 2; i++)
                        packed_lanes[2*c+i][39:32] = smp[c][i][7:0];
            // even samples then odd samples lane
            `SLSP_MODE_10:
                for (int c = 0; c < 4; c++)
                    for (int i = 0; i < 2; i++)
                        packed_lanes[2*c+i] = {smp[c][i][9:0],
                                               smp[c][i+2][9:0],
                                               smp[c][i+4][9:0],
                                               smp[c][i+6][9:0]};
            default: packed_lanes = '0;
        endcase
    end

    // ----------------------------------------------------------------
    // two-entry frame buffer
    // ----------------------------------------------------------------
    logic [LANES-1:0][OCTETS*8-1:0] spare_lanes;
    logic                           spare_valid;
    logic                           push;
    logic                           pop;
    logic                           take;
    logic                           next_out_valid;
    logic                           next_spare_valid;

    // frames of an unsupported mode are taken and dropped
    assign push = in_valid && in_ready;
    assign take = push && mode_ok;
    assign pop  = out_valid && out_ready;

    // occupancy after this cycle
    always_comb
    begin
        next_out_valid   = out_valid;
        next_spare_valid = spare_valid;
        if (!out_valid || pop)
        begin
            next_out_valid   = spare_valid || take;
            next_spare_valid = 1'b0;
        end
        else if (take)
            next_spare_valid = 1'b1;
    end

    // disabling the link flushes partial state
    always_ff @(posedge ref_clk)
    begin
        if (reset || !link_enable)
        begin
            out_valid   <= 1'b0;
            spare_valid <= 1'b0;
            in_ready    <= 1'b0;
        end
        else
        begin
            out_valid   <= next_out_valid;
            spare_valid <= next_spare_valid;
            in_ready    <= !next_spare_valid;
        end
    end

    // frame data registers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            lane_octets <= '0;
            spare_lanes <= '0;
        end
        else if (!out_valid || pop)
        begin
            if (spare_valid)
                lane_octets <= spare_lanes;
            else if (take)
                lane_octets <= packed_lanes;
        end
        else if (take)
            spare_lanes <= packed_lanes;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_mode1_lane1;
        @(posedge ref_clk) disable iff (reset)
        (active_mode == `SLSP_MODE_1) |->
            packed_lanes[1][39:24] == {samp_a[1][7:0], samp_b[0][11:4]};
    endproperty
    a_mode1_lane1: assert property (p_mode1_lane1)
        else $error("mode 1 lane 1 layout wrong");
    property p_mode2_lane3;
        @(posedge ref_clk) disable iff (reset)
        (active_mode == `SLSP_MODE_2) |->
            packed_lanes[3] == {samp_d[0][7:0], 32'h0000_0000};
    endproperty
    a_mode2_lane3: assert property (p_mode2_lane3)
        else $error("mode 2 lane 3 layout wrong");
    property p_mode3_lane2;
        @(posedge ref_clk) disable iff (reset)
        (active_mode == `SLSP_MODE_3) |->
            packed_lanes[2][29:20] == samp_c[1][9:0];
    endproperty
    a_mode3_lane2: assert property (p_mode3_lane2)
        else $error("mode 3 lane 2 layout wrong");
    property p_mode4_lane2;
        @(posedge ref_clk) disable iff (reset)
        (active_mode == `SLSP_MODE_4) |->
            packed_lanes[2][39:24] == {samp_c[0][3:0], samp_d[0]};
    endproperty
    a_mode4_lane2: assert property (p_mode4_lane2)
        else $error("mode 4 lane 2 layout wrong");
    property p_mode10_lane7;
        @(posedge ref_clk) disable iff (reset)
        (active_mode == `SLSP_MODE_10) |->
            packed_lanes[7][9:0] == samp_d[7][9:0];
    endproperty
    a_mode10_lane7: assert property (p_mode10_lane7)
        else $error("mode 10 lane 7 layout wrong");
    property p_mode9_lane5;
        @(posedge ref_clk) disable iff (reset)
        (active_mode == `SLSP_MODE_9) |->
            packed_lanes[5][39:32] == samp_c[1][7:0];
    endproperty
    a_mode9_lane5: assert property (p_mode9_lane5)
        else $error("mode 9 lane 5 layout wrong");
    property p_load_direct;
        @(posedge ref_clk) disable iff (reset)
        (take && !spare_valid && (!out_valid || pop) && link_enable) |=>
            out_valid && lane_octets == $past(packed_lanes);
    endproperty
    a_load_direct: assert property (p_load_direct)
        else $error("accepted frame not presented next cycle");
    property p_hold_stall;
        @(posedge ref_clk) disable iff (reset)
        (out_valid && !out_ready && link_enable) ##1 link_enable |->
            out_valid && $stable(lane_octets);
    endproperty
    a_hold_stall: assert property (p_hold_stall)
        else $error("frame changed while receiver stalled");
    property p_mode_frozen;
        @(posedge ref_clk) disable iff (reset)
        link_enable ##1 link_enable |-> $stable(active_mode);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen)
        else $error("mode changed while link enabled");
    property p_flush;
        @(posedge ref_clk) disable iff (reset)
        !link_enable |=> !out_valid && !in_ready;
    endproperty
    a_flush: assert property (p_flush)
        else $error("buffer not flushed while link disabled");

endmodule

//--- slsp_rx_model.sv
// receiver model: takes packed frames from the packer output
// assumes one clock shared with the packer, sync active high reset
`timescale 1ns/1ps

module slsp_rx_model
(
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire logic            slow,
    input  wire logic            out_valid,
    input  wire logic [7:0][39:0] lane_octets,
    output logic                 out_ready
);
    logic [1:0]       gap;
    logic [7:0][39:0] got [$];

    // ---------------------------------------------------------------
    // ready pacing
    // ---------------------------------------------------------------
    // free running phase for the slow pattern
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            gap <= 2'h0;
        else
            gap <= gap + 2'h1;
    end

    // ready every cycle, or one in four when stalling
    assign out_ready = !reset && (!slow || gap == 2'h3);

    // store every popped frame in arrival order
    always @(posedge ref_clk)
    begin
        if (!reset && out_valid && out_ready)
            got.push_back(lane_octets);
    end
endmodule

//--- serial_link_sample_packer_tb.sv
// self-checking bench of the sample packer with a receiver model
// assumes slsp_cfg.svh, slsp_pkg and slsp_packer compiled before it
`timescale 1ns/1ps

module serial_link_sample_packer_tb;
    logic                   ref_clk = 1'b0;
    logic                   reset = 1'b1;
    logic                   link_enable = 1'b1;
    slsp_pkg::slsp_mode_t   link_mode_select = 5'h0_001;
    logic [3:0][7:0][11:0]  smp = '0;
    logic                   in_valid = 1'b0;
    logic                   in_ready;
    logic [7:0][39:0]       lane_octets;
    logic                   out_valid;
    logic                   out_ready;
    slsp_pkg::slsp_cnt_t    frame_lanes;
    slsp_pkg::slsp_cnt_t    frame_octets;
    logic                   frame_64b66b;
    logic                   mode_bad;
    logic                   slow = 1'b0;
    logic                   saw_full = 1'b0;
    int                     bad_count = 0;
    int                     compares = 0;
    int                     cyc = 0;
    int                     cur = 1;
    logic [7:0][39:0]       expq [$];
    int tw[11] = '{0, 12, 8, 10, 12, 8, 12, 8, 12, 8, 10};
    int tl[11] = '{0, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8};
    int to[11] = '{0, 2, 1, 5, 2, 2, 2, 1, 3, 1, 5};
    int ts[11] = '{0, 2, 1, 4, 1, 1, 2, 1, 2, 2, 8};

    slsp_packer i_slsp_packer
    (
        .ref_clk          (ref_clk),
        .reset            (reset),
        .link_enable      (link_enable),
        .link_mode_select (link_mode_select),
        .samp_a           (smp[0]),
        .samp_b           (smp[1]),
        .samp_c           (smp[2]),
        .samp_d           (smp[3]),
        .in_valid         (in_valid),
        .in_ready         (in_ready),
        .lane_octets      (lane_octets),
        .out_valid        (out_valid),
        .out_ready        (out_ready),
        .frame_lanes      (frame_lanes),
        .frame_octets     (frame_octets),
        .frame_64b66b     (frame_64b66b),
        .mode_bad         (mode_bad)
    );

    slsp_rx_model i_slsp_rx_model
    (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .slow        (slow),
        .out_valid   (out_valid),
        .lane_octets (lane_octets),
        .out_ready   (out_ready)
    );

    // ---------------------------------------------------------------
    // clock, refusal watch and hang limit
    // ---------------------------------------------------------------
    // 4 ns period clock
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // note refusals, cut a hang short
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (in_valid && link_enable && in_ready === 1'b0)
            saw_full = 1'b1;
        if (cyc == 20000)
        begin
            bad_count = bad_count + 1;
            final_report();
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [319:0] seen,
                         input logic [319:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // lanes expected from the samples now driven, msb first
    function automatic logic [7:0][39:0] expect_lanes(input int m);
        int               pos;
        int               i;
        int               lb;
        logic [319:0]     s;
        logic [7:0][39:0] r;
        s = '0;
        r = '0;
        pos = 0;
        lb = to[m] * 8;
        for (int c = 0; c < 4; c++)
            for (int p = 0; p < ts[m]; p++)
            begin
                i = (m == 10) ? ((p < 4) ? 2 * p : 2 * p - 7) : p;
                for (int b = tw[m] - 1; b >= 0; b--)
                begin
                    s[319 - pos] = smp[c][i][b];
                    pos++;
                end
            end
        for (int k = 0; k < tl[m]; k++)
            for (int b = 0; b < lb; b++)
                r[k][39 - b] = s[319 - k * lb - b];
        return r;
    endfunction

    task automatic set_mode(input int m);
        link_enable = 1'b0;
        link_mode_select = 5'(m);
        cur = m;
        tick(2);
        link_enable = 1'b1;
        if (m >= 1 && m <= 10)
        begin
            check("lanes", frame_lanes, tl[m]);
            check("octets", frame_octets, to[m]);
            check("enc", frame_64b66b, m >= 4 && m <= 8);
        end
        else
            check("lanes", frame_lanes, 0);
        check("bad", mode_bad, !(m >= 1 && m <= 10));
        tick(1);
    endtask

    // offer one frame, hold it until taken; in_valid left high
    task automatic send(input int f);
        int w;
        w = (cur >= 1 && cur <= 10) ? tw[cur] : 12;
        for (int c = 0; c < 4; c++)
            for (int i = 0; i < 8; i++)
                smp[c][i] = 12'((c * 37 + i * 11 + f * 53 + 5) * 29)
                            & 12'((1 << w) - 1);
        if (cur >= 1 && cur <= 10)
            expq.push_back(expect_lanes(cur));
        in_valid = 1'b1;
        while (in_ready !== 1'b1)
            tick(1);
        tick(1);
    endtask

    // wait for n frames at the receiver and compare in order
    task automatic drain(input int n);
        int t;
        t = 0;
        while (i_slsp_rx_model.got.size() < n && t < 300)
        begin
            tick(1);
            t++;
        end
        check("count", i_slsp_rx_model.got.size(), n);
        while (i_slsp_rx_model.got.size() > 0 && expq.size() > 0)
            check("frame", i_slsp_rx_model.got.pop_front(),
                  expq.pop_front());
        tick(2);
        check("empty", out_valid, 1'b0);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        tick(20);
        check("rst ready", in_ready, 1'b0);
        check("rst valid", out_valid, 1'b0);
        check("rst data", lane_octets, '0);
        check("rst lanes", frame_lanes, 6);
        reset = 1'b0;
        tick(1);
    endtask

    task automatic t_modes();
        for (int m = 1; m <= 10; m++)
        begin
            set_mode(m);
            send(m);
            in_valid = 1'b0;
            drain(1);
        end
    endtask

    // stalled receiver fills the buffer, order kept on drain
    task automatic t_stall();
        slow = 1'b1;
        set_mode(3);
        for (int f = 0; f < 4; f++)
            send(20 + f);
        in_valid = 1'b0;
        check("refused", saw_full, 1'b1);
        drain(4);
        slow = 1'b0;
    endtask

    // unsupported modes drop frames
    task automatic t_badmode();
        int bm[3] = '{0, 11, 31};
        for (int j = 0; j < 3; j++)
        begin
            set_mode(bm[j]);
            send(40);
            in_valid = 1'b0;
            tick(6);
            check("dropped", i_slsp_rx_model.got.size(), 0);
            check("no out", out_valid, 1'b0);
        end
    endtask

    // main sequence
    initial
    begin
        t_reset();
        t_modes();
        t_stall();
        t_badmode();
        final_report();
    end
endmodule
